/* hw/pls_supervisor.sv */
// Purpose: protection supervisor: transient/overload timers, latch window, thermal off
// Assumes: comparator levels arrive asynchronously, active high
// Notes:   all outputs registered; one clock, synchronous active-low reset
// Notes on behaviour
// [RQ1] keep switching while current sense sits above the transient threshold
// [RQ2] start the transient timer on the transient threshold, longer than overload
// [RQ3] transient timer expiry enters protection, latched or auto-recovered per option
// [RQ4] escalation to current limit also runs the overload timer
// [RQ5] run only inside the latch window; leaving it latches off
// [RQ6] blank high latch events under 50 us and low under 350 us
// [RQ7] latched-off clears only on brown-out or supply reset
// [RQ8] ignore latch until start level; then check high latch before switching
// [RQ9] low latch evaluated only after soft-start finishes
// [RQ10] doubled thermistor bias during soft-start, normal afterwards
// [RQ11] thermal flag stops switching at once, enters low-power off; code ignores the flag in PLS_LATCH, so no low-power off there
// [RQ12] keep supply alive during thermal shutdown
// [RQ13] thermal flag clear restarts a normal start-up sequence
// [RQ14] overload timer resets when sense drops below current limit
// [RQ15] auto-recovery: stop gate pulses and restart after the delay
// [RQ16] all timers are oscillator-clocked counters with derived terminal counts
`timescale 1ns/1ns
module pls_supervisor #(
    parameter int unsigned TRAN_CYC     = pls_pkg::TRAN_CYC,
    parameter int unsigned FAULT_CYC    = pls_pkg::FAULT_CYC,
    parameter int unsigned LO_BLANK_CYC = pls_pkg::LO_BLANK_CYC,
    parameter int unsigned SSTART_CYC   = pls_pkg::SSTART_CYC,
    parameter int unsigned AUTOREC_CYC  = pls_pkg::AUTOREC_CYC,
    parameter bit          AUTO_RECOVERY = pls_pkg::AUTO_RECOVERY
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic cs_tran_cmp,            // sense above transient threshold
    input  wire logic cs_limit_cmp,           // setpoint at current_limit_level
    input  wire logic latch_hi_cmp,           // latch pin above high threshold
    input  wire logic latch_lo_cmp,           // latch pin below low threshold
    input  wire logic supply_start_level,     // supply reached start level
    input  wire logic brownout,               // brown-out detected
    input  wire logic supply_reset,           // supply fell to reset voltage
    input  wire logic thermal_shutdown_flag,  // die over temperature
    output logic      gate_drive_en,
    output logic      latched_off,
    output logic      protect_mode,
    output logic      restart_req,
    output logic      softstart_bias_current,
    output logic      low_power_off,
    output logic      supply_keep_alive
);
    localparam int unsigned NSYNC = 8;

    // ==========================================================
    // input synchronisers: stage one is read only by stage two
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {cs_tran_cmp, cs_limit_cmp, latch_hi_cmp, latch_lo_cmp,
                        supply_start_level, brownout, supply_reset, thermal_shutdown_flag};
            sync2_q <= sync1_q;
        end
    end

    logic tran_s, lim_s, hi_s, lo_s, von_s, bo_s, rst_s, tsd_s, clr_s;
    assign {tran_s, lim_s, hi_s, lo_s, von_s, bo_s, rst_s, tsd_s} = sync2_q;
    assign clr_s = bo_s || rst_s;

    // ==========================================================
    // state register
    pls_pkg::pls_state_t state_q;
    pls_pkg::pls_state_t state_d;

    function automatic logic is_switching(input pls_pkg::pls_state_t st);
        is_switching = (st == pls_pkg::PLS_SOFT) || (st == pls_pkg::PLS_RUN);
    endfunction : is_switching

    // ==========================================================
    // protection counters, all on the oscillator clock [RQ16]
    logic tran_done, fault_done, hi_qual, lo_qual, ss_done, ar_done;

    // transient timer runs while above the lower threshold [RQ2]
    pls_timer #(.LIMIT(TRAN_CYC)) u_tran (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .en    (tran_s && is_switching(state_q)),
        .done  (tran_done)
    );

    // overload timer also runs on escalation, clears below the limit [RQ4] [RQ14]
    pls_timer #(.LIMIT(FAULT_CYC)) u_fault (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .en    (lim_s && is_switching(state_q)),
        .done  (fault_done)
    );

    // high latch blanking, armed from start level on [RQ6] [RQ8]
    pls_timer #(.LIMIT(pls_pkg::HI_BLANK_CYC)) u_hi (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .en    (hi_s && is_switching(state_q)),
        .done  (hi_qual)
    );

    // low latch blanking, armed only after soft-start [RQ6] [RQ9]
    pls_timer #(.LIMIT(LO_BLANK_CYC)) u_lo (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .en    (lo_s && (state_q == pls_pkg::PLS_RUN)),
        .done  (lo_qual)
    );

    pls_timer #(.LIMIT(SSTART_CYC)) u_ss (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .en    (state_q == pls_pkg::PLS_SOFT),
        .done  (ss_done)
    );
    pls_timer #(.LIMIT(AUTOREC_CYC)) u_ar (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .en    (state_q == pls_pkg::PLS_RECOV),
        .done  (ar_done)
    );

    // timer expiry: target depends on the build option [RQ3] [RQ15]
    logic                timer_fault;
    pls_pkg::pls_state_t fault_tgt;
    assign timer_fault = tran_done || fault_done;
    assign fault_tgt   = AUTO_RECOVERY ? pls_pkg::PLS_RECOV : pls_pkg::PLS_LATCH;

    // ==========================================================
    // next state: thermal first, then latch release, then faults
    // a held latch ignores the thermal flag, else its clear would release the latch
    always_comb begin
        state_d = state_q;
        if (tsd_s && (state_q != pls_pkg::PLS_LATCH)) begin
            state_d = pls_pkg::PLS_THERM;                    // [RQ11]
        end else if (clr_s) begin
            state_d = pls_pkg::PLS_WAIT;                     // [RQ7]
        end else begin
            case (state_q)
                pls_pkg::PLS_WAIT: begin
                    // high latch level checked before any switching
                    if (von_s) begin
                        state_d = hi_s ? pls_pkg::PLS_LATCH : pls_pkg::PLS_SOFT; // [RQ8]
                    end
                end
                pls_pkg::PLS_SOFT: begin
                    if (hi_qual) begin
                        state_d = pls_pkg::PLS_LATCH;        // [RQ5]
                    end else if (timer_fault) begin
                        state_d = fault_tgt;                 // [RQ3]
                    end else if (ss_done) begin
                        state_d = pls_pkg::PLS_RUN;
                    end
                end
                pls_pkg::PLS_RUN: begin
                    // latch window wins over timers: never auto-recovered
                    if (hi_qual || lo_qual) begin
                        state_d = pls_pkg::PLS_LATCH;        // [RQ5]
                    end else if (timer_fault) begin
                        state_d = fault_tgt;                 // [RQ3]
                    end
                end
                pls_pkg::PLS_RECOV: begin
                    if (ar_done) begin
                        state_d = pls_pkg::PLS_WAIT;         // [RQ15]
                    end
                end
                pls_pkg::PLS_LATCH: begin
                    state_d = pls_pkg::PLS_LATCH;            // [RQ7]
                end
                pls_pkg::PLS_THERM: begin
                    state_d = pls_pkg::PLS_WAIT;             // [RQ13]
                end
                default: begin
                    state_d = pls_pkg::PLS_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= pls_pkg::PLS_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // gate enable: switches through transient load until a timer ends
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            gate_drive_en <= 1'b0;
        end else begin
            gate_drive_en <= is_switching(state_q) && !tsd_s; // [RQ1] [RQ11]
        end
    end

    // status outputs; supply kept up in thermal off so the state is not lost
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            latched_off            <= 1'b0;
            protect_mode           <= 1'b0;
            low_power_off          <= 1'b0;
            supply_keep_alive      <= 1'b0;
            softstart_bias_current <= 1'b0;
        end else begin
            latched_off            <= (state_q == pls_pkg::PLS_LATCH);
            protect_mode           <= (state_q == pls_pkg::PLS_LATCH) || (state_q == pls_pkg::PLS_RECOV);
            low_power_off          <= (state_q == pls_pkg::PLS_THERM); // [RQ11]
            supply_keep_alive      <= (state_q == pls_pkg::PLS_THERM) || (state_q == pls_pkg::PLS_LATCH); // [RQ12]
            softstart_bias_current <= (state_q == pls_pkg::PLS_SOFT); // [RQ10] faster latch-pin charge
        end
    end

    // one-cycle restart request at the end of the recovery delay
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            restart_req <= 1'b0;
        end else begin
            restart_req <= (state_q == pls_pkg::PLS_RECOV) && (state_d == pls_pkg::PLS_WAIT) && !clr_s; // [RQ15]
        end
    end

    // ==========================================================
    // assertions
    property p_tsd_stop;
        @(posedge sys_clk) disable iff (!rst_n)
            tsd_s && (state_q != pls_pkg::PLS_LATCH) |=> !gate_drive_en ##1 low_power_off;
    endproperty
    a_tsd_stop: assert property (p_tsd_stop) else $error("gate not stopped on thermal flag"); // [RQ11]

    property p_keep_alive;
        @(posedge sys_clk) disable iff (!rst_n) (state_q == pls_pkg::PLS_THERM) |=> supply_keep_alive;
    endproperty
    a_keep_alive: assert property (p_keep_alive) else $error("supply dropped in thermal off"); // [RQ12]

    property p_therm_restart;
        @(posedge sys_clk) disable iff (!rst_n)
            (state_q == pls_pkg::PLS_THERM) && !tsd_s |=> (state_q == pls_pkg::PLS_WAIT);
    endproperty
    a_therm_restart: assert property (p_therm_restart) else $error("no restart after thermal clear"); // [RQ13]

    property p_run_switch;
        @(posedge sys_clk) disable iff (!rst_n)
            (state_q == pls_pkg::PLS_RUN) && tran_s && !tsd_s |=> gate_drive_en;
    endproperty
    a_run_switch: assert property (p_run_switch) else $error("switching stopped in transient"); // [RQ1]

    property p_tran_protect;
        @(posedge sys_clk) disable iff (!rst_n)
            (state_q == pls_pkg::PLS_RUN) && tran_done && !hi_qual && !lo_qual && !tsd_s && !clr_s
            |=> (state_q == fault_tgt) ##1 protect_mode;
    endproperty
    a_tran_protect: assert property (p_tran_protect) else $error("transient expiry missed"); // [RQ3]

    property p_fault_reset;
        @(posedge sys_clk) disable iff (!rst_n) !lim_s |=> !fault_done;
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("overload timer not reset"); // [RQ14]

    property p_latch_hold;
        @(posedge sys_clk) disable iff (!rst_n)
            (state_q == pls_pkg::PLS_LATCH) && !clr_s |=> (state_q == pls_pkg::PLS_LATCH);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch released without clear"); // [RQ7]

    property p_hi_start;
        @(posedge sys_clk) disable iff (!rst_n)
            (state_q == pls_pkg::PLS_WAIT) && von_s && hi_s && !tsd_s && !clr_s
            |=> (state_q == pls_pkg::PLS_LATCH) ##1 !gate_drive_en;
    endproperty
    a_hi_start: assert property (p_hi_start) else $error("started with high latch set"); // [RQ8]

    property p_lo_ignored;
        @(posedge sys_clk) disable iff (!rst_n) (state_q == pls_pkg::PLS_SOFT) |-> !lo_qual;
    endproperty
    a_lo_ignored: assert property (p_lo_ignored) else $error("low latch seen in soft-start"); // [RQ9]

    property p_bias;
        @(posedge sys_clk) disable iff (!rst_n) (state_q == pls_pkg::PLS_SOFT) |=> softstart_bias_current;
    endproperty
    a_bias: assert property (p_bias) else $error("bias not doubled in soft-start"); // [RQ10]

    property p_recov;
        @(posedge sys_clk) disable iff (!rst_n)
            (state_q == pls_pkg::PLS_RECOV) && ar_done && !tsd_s && !clr_s |=> restart_req && !gate_drive_en;
    endproperty
    a_recov: assert property (p_recov) else $error("no restart after recovery delay"); // [RQ15]

    c_latch: cover property (@(posedge sys_clk) disable iff (!rst_n) state_q == pls_pkg::PLS_LATCH);
    c_therm: cover property (@(posedge sys_clk) disable iff (!rst_n) state_q == pls_pkg::PLS_THERM);
    c_run:   cover property (@(posedge sys_clk) disable iff (!rst_n) state_q == pls_pkg::PLS_RUN);
endmodule : pls_supervisor

/* hw/pls_pkg.sv */
// Purpose: shared constants and types of the protection latch supervisor
// Assumes: 20 MHz internal oscillator clock, 65 kHz switching variant
// Notes:   cycle counts derive from the printed times and the clock rate
package pls_pkg;
    // ==========================================================
    // clock rate
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned CLK_MHZ       = CLK_HZ / 1_000_000;
    localparam int unsigned CLK_KHZ       = CLK_HZ / 1_000;

    // ==========================================================
    // printed times, in their own units
    localparam int unsigned TRAN_S        = 6;    // transient timer, typical
    localparam int unsigned HI_BLANK_US   = 50;   // high latch blanking, 65 kHz
    localparam int unsigned LO_BLANK_US   = 350;  // low latch blanking
    localparam int unsigned SSTART_MS     = 8;    // soft-start length, plain default
    localparam int unsigned FAULT_MS      = 128;  // overload timer, plain default
    localparam int unsigned AUTOREC_MS    = 1000; // auto-recovery delay, plain default

    // ==========================================================
    // derived cycle counts (least times, whole cycles)
    localparam int unsigned TRAN_CYC      = TRAN_S * CLK_HZ;
    localparam int unsigned HI_BLANK_CYC  = HI_BLANK_US * CLK_MHZ;
    localparam int unsigned LO_BLANK_CYC  = LO_BLANK_US * CLK_MHZ;
    localparam int unsigned SSTART_CYC    = SSTART_MS * CLK_KHZ;
    localparam int unsigned FAULT_CYC     = FAULT_MS * CLK_KHZ;
    localparam int unsigned AUTOREC_CYC   = AUTOREC_MS * CLK_KHZ;

    // ==========================================================
    // build option: 1 = auto-recovery, 0 = latched
    localparam bit          AUTO_RECOVERY = 1'b0;

    // ==========================================================
    // supervisor states
    typedef enum logic [2:0] {
        PLS_WAIT  = 3'b000,  // waiting for supply start level
        PLS_SOFT  = 3'b001,  // soft-start, switching
        PLS_RUN   = 3'b010,  // normal switching
        PLS_RECOV = 3'b011,  // auto-recovery delay
        PLS_LATCH = 3'b100,  // latched off
        PLS_THERM = 3'b101   // thermal shutdown, low-power off
    } pls_state_t;
endpackage : pls_pkg

/* hw/pls_timer.sv */
// Purpose: enable-gated protection counter with a sticky terminal flag
// Assumes: en is synchronous to clk
// Notes:   dropping en clears count and flag on the next edge
`timescale 1ns/1ns
module pls_timer #(
    parameter int unsigned LIMIT = 16
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    output logic      done
);
    localparam logic [31:0] LAST = 32'(LIMIT - 1);

    logic [31:0] cnt_q;

    // ==========================================================
    // counter: saturates at the last count so done stays up
    always_ff @(posedge clk) begin
        if (!rst_n || !en) begin
            cnt_q <= 32'h0000_0000;
        end else if (cnt_q != LAST) begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    // flag rises after LIMIT enabled cycles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else begin
            done <= en && (cnt_q >= LAST);
        end
    end
endmodule : pls_timer

/* tb/pls_analog_model.sv */
// Purpose: behavioural model of the analog comparators facing the supervisor
// Assumes: the bench sets the wanted comparator levels on level_req
// Notes:   outputs move a few ns after a request, like an unclocked comparator
`timescale 1ns/1ns
module pls_analog_model (
    input  wire logic [7:0] level_req,
    output logic            cs_tran_cmp,
    output logic            cs_limit_cmp,
    output logic            latch_hi_cmp,
    output logic            latch_lo_cmp,
    output logic            supply_start_level,
    output logic            brownout,
    output logic            supply_reset,
    output logic            thermal_shutdown_flag
);
    // ==========================================================
    // comparator outputs
    // async levels with a small lag, so they never line up with the clock edge
    initial {thermal_shutdown_flag, supply_reset, brownout, supply_start_level,
             latch_lo_cmp, latch_hi_cmp, cs_limit_cmp, cs_tran_cmp} = 8'h00;
    always @(level_req) begin
        {thermal_shutdown_flag, supply_reset, brownout, supply_start_level,
         latch_lo_cmp, latch_hi_cmp, cs_limit_cmp, cs_tran_cmp} <= #3 level_req;
    end
endmodule : pls_analog_model

/* tb/protection_latch_supervisor_bench.sv */
// Purpose: self-checking bench of the protection supervisor
// Assumes: shortened timer parameters; a second instance built for auto-recovery
// Notes:   both instances share the comparators; outs[13:7] belong to the auto-recovery one
`timescale 1ns/1ns
module protection_latch_supervisor_bench;
    // ==========================================================
    // setup
    localparam int TRAN = 120, FAULT = 60, LOBL = 100, SST = 200, HIBL = 1000, ARD = 50;
    localparam int I_TRAN = 0, I_LIM = 1, I_HI = 2, I_LO = 3, I_START = 4, I_BO = 5, I_SRST = 6, I_TH = 7;
    localparam int O_GATE = 0, O_LATCH = 1, O_PROT = 2, O_RST = 3, O_BIAS = 4, O_LPO = 5, O_KEEP = 6, AR = 7;
    logic       sys_clk;
    logic       rst_n;
    logic [7:0] req;
    wire [13:0] outs;
    logic       c_tran, c_lim, c_hi, c_lo, c_start, c_bo, c_srst, c_th;
    int         failures;
    int         checked;
    int         cycles;

    pls_analog_model u_pls_analog_model (
        .level_req(req), .cs_tran_cmp(c_tran), .cs_limit_cmp(c_lim), .latch_hi_cmp(c_hi),
        .latch_lo_cmp(c_lo), .supply_start_level(c_start), .brownout(c_bo),
        .supply_reset(c_srst), .thermal_shutdown_flag(c_th));

    pls_supervisor #(.TRAN_CYC(TRAN), .FAULT_CYC(FAULT), .LO_BLANK_CYC(LOBL),
                     .SSTART_CYC(SST), .AUTOREC_CYC(ARD)) u_pls_supervisor (
        .sys_clk(sys_clk), .rst_n(rst_n), .cs_tran_cmp(c_tran), .cs_limit_cmp(c_lim),
        .latch_hi_cmp(c_hi), .latch_lo_cmp(c_lo), .supply_start_level(c_start),
        .brownout(c_bo), .supply_reset(c_srst), .thermal_shutdown_flag(c_th),
        .gate_drive_en(outs[0]), .latched_off(outs[1]), .protect_mode(outs[2]),
        .restart_req(outs[3]), .softstart_bias_current(outs[4]), .low_power_off(outs[5]),
        .supply_keep_alive(outs[6]));

    // same comparators, auto-recovery build: timer faults restart instead of latching
    pls_supervisor #(.TRAN_CYC(TRAN), .FAULT_CYC(FAULT), .LO_BLANK_CYC(LOBL), .SSTART_CYC(SST),
                     .AUTOREC_CYC(ARD), .AUTO_RECOVERY(1'b1)) u_pls_supervisor_ar (
        .sys_clk(sys_clk), .rst_n(rst_n), .cs_tran_cmp(c_tran), .cs_limit_cmp(c_lim),
        .latch_hi_cmp(c_hi), .latch_lo_cmp(c_lo), .supply_start_level(c_start),
        .brownout(c_bo), .supply_reset(c_srst), .thermal_shutdown_flag(c_th),
        .gate_drive_en(outs[7]), .latched_off(outs[8]), .protect_mode(outs[9]),
        .restart_req(outs[10]), .softstart_bias_current(outs[11]), .low_power_off(outs[12]),
        .supply_keep_alive(outs[13]));

    // ==========================================================
    // clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            test_done();
        end
    end

    // ==========================================================
    // shared tasks
    // inputs always change 5 ns after the edge, never on it
    task automatic go(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask : go
    task automatic expect_bit(input logic act, input logic exp, input string what);
        checked++;
        if (act !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s", $time, what);
        end
    endtask : expect_bit
    // bounded poll on an output, then judge it
    task automatic wait_out(input int idx, input logic v, input int lim, input string what);
        int n;
        n = 0;
        while (outs[idx] !== v && n < lim) begin
            go(1);
            n++;
        end
        expect_bit(outs[idx], v, what);
    endtask : wait_out
    task automatic start_up();
        req[I_START] = 1'b1;
        wait_out(O_GATE, 1'b1, 8, "gate on at start level");
        expect_bit(outs[O_BIAS], 1'b1, "doubled bias in soft-start");
        go(SST + 8);
        expect_bit(outs[O_BIAS], 1'b0, "normal bias after soft-start");
    endtask : start_up
    // supply-side release; brown-out or supply reset per caller
    task automatic recover(input int src);
        req = 8'h00;
        req[src] = 1'b1;
        go(6);
        req = 8'h00;
        go(6);
        expect_bit(outs[O_LATCH], 1'b0, "latch released");
        expect_bit(outs[O_KEEP], 1'b0, "keep-alive dropped");
    endtask : recover

    // ==========================================================
    // scenarios
    task automatic t_transient();
        start_up();
        req[I_TRAN] = 1'b1;
        go(TRAN - 10);
        expect_bit(outs[O_GATE], 1'b1, "switching above transient level");
        expect_bit(outs[O_LATCH], 1'b0, "transient timer not yet out");
        wait_out(O_LATCH, 1'b1, 20, "transient timer expiry latches");
        expect_bit(outs[O_GATE], 1'b0, "gate stopped in protection");
        expect_bit(outs[O_PROT], 1'b1, "protection mode");
        expect_bit(outs[AR + O_LATCH], 1'b0, "transient expiry not latched in auto build");
        req[I_TRAN] = 1'b0;
        go(50);
        expect_bit(outs[O_LATCH], 1'b1, "latch holds without release");
        recover(I_BO);
    endtask : t_transient
    task automatic t_overload();
        start_up();
        req[I_LIM] = 1'b1;
        go(FAULT - 20);
        req[I_LIM] = 1'b0;
        go(4);
        req[I_LIM] = 1'b1;
        go(FAULT - 20);
        expect_bit(outs[O_LATCH], 1'b0, "overload timer restarted");
        wait_out(O_LATCH, 1'b1, 30, "overload timer expiry latches");
        expect_bit(outs[AR + O_LATCH], 1'b0, "auto-recovery build not latched");
        expect_bit(outs[AR + O_PROT], 1'b1, "auto-recovery protection mode");
        expect_bit(outs[AR + O_GATE], 1'b0, "gate pulses stopped in recovery");
        wait_out(AR + O_RST, 1'b1, ARD + 10, "restart after recovery delay");
        go(1);
        expect_bit(outs[AR + O_RST], 1'b0, "restart request lasts one cycle");
        wait_out(AR + O_GATE, 1'b1, 4, "switching resumes after restart");
        expect_bit(outs[O_LATCH], 1'b1, "latched build stays off");
        recover(I_SRST);
    endtask : t_overload
    task automatic t_high_latch();
        start_up();
        req[I_HI] = 1'b1;
        go(HIBL - 100);
        req[I_HI] = 1'b0;
        go(10);
        expect_bit(outs[O_LATCH], 1'b0, "short high spike blanked");
        req[I_HI] = 1'b1;
        go(HIBL);
        wait_out(O_LATCH, 1'b1, 20, "long high latch event");
        expect_bit(outs[O_GATE], 1'b0, "gate off when latched");
        recover(I_SRST);
    endtask : t_high_latch
    task automatic t_low_latch();
        req[I_START] = 1'b1;
        req[I_LO] = 1'b1;
        go(8);
        expect_bit(outs[O_GATE], 1'b1, "low latch ignored at start");
        go(SST - 30);
        expect_bit(outs[O_GATE], 1'b1, "low latch ignored in soft-start");
        req[I_LO] = 1'b0;
        go(40);
        req[I_LO] = 1'b1;
        go(LOBL - 20);
        req[I_LO] = 1'b0;
        go(10);
        expect_bit(outs[O_LATCH], 1'b0, "short low spike blanked");
        req[I_LO] = 1'b1;
        wait_out(O_LATCH, 1'b1, LOBL + 20, "long low latch event");
        recover(I_BO);
    endtask : t_low_latch
    task automatic t_start_hi();
        req[I_HI] = 1'b1;
        req[I_START] = 1'b1;
        go(30);
        expect_bit(outs[O_GATE], 1'b0, "no switching with high latch at start");
        expect_bit(outs[O_LATCH], 1'b1, "latched at start on high latch");
        req[I_TH] = 1'b1;
        go(8);
        req[I_TH] = 1'b0;
        go(8);
        expect_bit(outs[O_LATCH], 1'b1, "thermal trip keeps the latch");
        recover(I_BO);
    endtask : t_start_hi
    task automatic t_thermal();
        start_up();
        req[I_TH] = 1'b1;
        wait_out(O_GATE, 1'b0, 6, "thermal stops switching");
        wait_out(O_LPO, 1'b1, 4, "low-power off");
        expect_bit(outs[O_KEEP], 1'b1, "supply kept alive");
        req[I_TH] = 1'b0;
        wait_out(O_GATE, 1'b1, 10, "restart after thermal clear");
        expect_bit(outs[O_BIAS], 1'b1, "new soft-start after thermal");
        expect_bit(outs[O_LPO], 1'b0, "low-power off left");
        recover(I_BO);
    endtask : t_thermal

    // ==========================================================
    // verdict
    task automatic test_done();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        req = 8'h00;
        failures = 0;
        checked = 0;
        cycles = 0;
        go(20);
        rst_n = 1'b1;
        go(2);
        expect_bit(outs[O_GATE], 1'b0, "gate off after reset");
        t_transient();
        t_overload();
        t_high_latch();
        t_low_latch();
        t_start_hi();
        t_thermal();
        test_done();
    end
endmodule : protection_latch_supervisor_bench
